// >>> hw/e1_ssm_code_transceiver.sv
// E1 synchronization status code unit: inserts a 4-bit quality code into
// a national or international overhead bit and qualifies the received code.
// Assumes an AXI4-Lite master on aclk and a framer giving frame strobes.
//
// Overview of operation
// RULE1: Code rides one Sa4..Sa8 bit or Si.
// RULE2: Send code MSB first from frame 2.
// RULE3: Four-bit quality codes; others are reserved.
// RULE4: Source bit 7 picks national or Si.
// RULE5: Inserted code overrides ordinary national bit content.
// RULE6: Software enables one national slot at most.
// RULE7: Software enables CRC multiframe before Si.
// RULE8: Match filter bits 6:5 need 0/3/5/7; code uses 1/3/5/7.
// RULE9: Receiver monitors only while bit 4 set.
// RULE10: Reset bit 3 restores defaults, self clears.
// RULE11: Receive filter bits 2:1 need 0/3/5/7; code uses 1/3/5/7.
// RULE12: Send bit 0 starts code, self clears.
// RULE13: Qualified code to 3:0, prior to 7:4.
// RULE14: Compare qualified code with first expected code.
// RULE15: Three expected codes, each with alarm.
// RULE16: Changed qualified code raises change alarm.
// RULE17: Repeat count sets sends; zero is continuous.
// RULE18: Transmit code held in bits 3:0.
// RULE19: Different code restarts consecutive pattern counters.
// RULE20: After last repeat, selected bit sends ones.
`timescale 1ns/100ps
`include "ssm_consts.svh"

module e1_ssm_code_transceiver #(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Framer overhead
  input wire ssm_pkg::frame_side_t frame_in,
  output ssm_pkg::tx_side_t tx_out
);
  import ssm_pkg::*;

  logic [AW-1:0] aw_addr_r;
  logic aw_full_r;
  logic [7:0] w_data_r;
  logic w_lane_r;
  logic w_full_r;
  logic wr_do;
  reg_sel_t wr_sel;
  logic code_reset;
  logic send_req;
  logic [7:0] control_r;
  logic [3:0] expect_r [3];
  logic [3:0] tx_code_r;
  logic [7:0] repeat_r;
  logic [4:0] slot_en_r;
  logic [7:0] history_r;
  logic [`ST_WIDTH-1:0] status_r;
  logic [`ST_WIDTH-1:0] status_set;
  tx_state_t tx_state_r;
  logic [3:0] tx_word_r;
  logic [7:0] tx_left_r;
  logic tx_cont_r;
  logic slot;
  logic [1:0] pos;
  logic ins_bit;
  logic rx_bit;
  logic [2:0] rx_shift_r;
  logic rx_run_r;
  logic rx_stb_r;
  logic [3:0] rx_code_r;
  logic rx_pass;
  logic [3:0] rx_pass_code;
  logic match_pass;
  logic [3:0] match_code;

  // Register select from a byte address; low two bits ignored
  function automatic reg_sel_t decode(input logic [AW-1:0] a);
    case (a[11:2])
      `SSM_IDX_CONTROL: decode = SEL_CONTROL;
      `SSM_IDX_HISTORY: decode = SEL_HISTORY;
      `SSM_IDX_EXPECT1: decode = SEL_EXPECT1;
      `SSM_IDX_EXPECT2: decode = SEL_EXPECT2;
      `SSM_IDX_EXPECT3: decode = SEL_EXPECT3;
      `SSM_IDX_TX_CODE: decode = SEL_TX_CODE;
      `SSM_IDX_REPEAT: decode = SEL_REPEAT;
      `SSM_IDX_STATUS: decode = SEL_STATUS;
      `SSM_IDX_SLOT_EN: decode = SEL_SLOT_EN;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // Write address channel; held until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      awready <= 1'b0;
      aw_addr_r <= '0;
    end else if (awvalid && awready) begin
      aw_full_r <= 1'b1;
      awready <= 1'b0;
      aw_addr_r <= awaddr;
    end else if (bvalid && bready) begin
      aw_full_r <= 1'b0;
      awready <= 1'b1;
    end else if (!aw_full_r) begin
      awready <= 1'b1;
    end
  end

  // Write data channel; only byte lane 0 carries register data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      wready <= 1'b0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
    end else if (wvalid && wready) begin
      w_full_r <= 1'b1;
      wready <= 1'b0;
      w_data_r <= wdata[7:0];
      w_lane_r <= wstrb[0];
    end else if (bvalid && bready) begin
      w_full_r <= 1'b0;
      wready <= 1'b1;
    end else if (!w_full_r) begin
      wready <= 1'b1;
    end
  end

  assign wr_do = aw_full_r && w_full_r && !bvalid;
  assign wr_sel = decode(aw_addr_r);
  // RULE10: reset pulse
  assign code_reset = wr_do && w_lane_r && wr_sel == SEL_CONTROL && w_data_r[`CTL_RST_BIT];
  // RULE12: send pulse, reset wins
  assign send_req = wr_do && w_lane_r && wr_sel == SEL_CONTROL && w_data_r[`CTL_SEND_BIT]
                    && !w_data_r[`CTL_RST_BIT];

  // Write response once both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Software registers; the code unit reset spares the status bits
  always_ff @(posedge aclk) begin
    if (!aresetn || code_reset) begin
      control_r <= `RST_CONTROL;
      expect_r[0] <= `RST_EXPECT;
      expect_r[1] <= `RST_EXPECT;
      expect_r[2] <= `RST_EXPECT;
      tx_code_r <= `RST_TX_CODE;
      repeat_r <= `RST_REPEAT;
      slot_en_r <= `RST_SLOT_EN;
    end else if (wr_do && w_lane_r) begin
      case (wr_sel)
        // RULE12: strobe bits are not stored
        SEL_CONTROL: control_r <= w_data_r & `CTL_STORE_MASK;
        SEL_EXPECT1: expect_r[0] <= w_data_r[3:0];
        SEL_EXPECT2: expect_r[1] <= w_data_r[3:0];
        SEL_EXPECT3: expect_r[2] <= w_data_r[3:0];
        // RULE18: code in low nibble
        SEL_TX_CODE: tx_code_r <= w_data_r[3:0];
        SEL_REPEAT: repeat_r <= w_data_r;
        SEL_SLOT_EN: slot_en_r <= w_data_r[4:0];
        default: ;
      endcase
    end
  end

  // Read channel; registered data, one item at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= (decode(araddr) == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      case (decode(araddr))
        SEL_CONTROL: rdata <= {24'h000000, control_r};
        SEL_HISTORY: rdata <= {24'h000000, history_r};
        SEL_EXPECT1: rdata <= {28'h0000000, expect_r[0]};
        SEL_EXPECT2: rdata <= {28'h0000000, expect_r[1]};
        SEL_EXPECT3: rdata <= {28'h0000000, expect_r[2]};
        SEL_TX_CODE: rdata <= {28'h0000000, tx_code_r};
        SEL_REPEAT: rdata <= {24'h000000, repeat_r};
        SEL_STATUS: rdata <= {26'h0, status_r};
        SEL_SLOT_EN: rdata <= {27'h0, slot_en_r};
        default: rdata <= 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // RULE2: odd frame index carries code bits, index 1 is frame 2
  assign slot = frame_in.frame_tick && frame_in.frame_num[0];
  assign pos = frame_in.frame_num[2:1];

  // Transmit sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn || code_reset) begin
      tx_state_r <= TX_PASS;
      tx_word_r <= 4'h0;
      tx_left_r <= 8'h00;
      tx_cont_r <= 1'b0;
    end else if (send_req) begin
      // RULE12: latch code and count
      tx_state_r <= TX_ALIGN;
      tx_word_r <= tx_code_r;
      tx_left_r <= repeat_r;
      tx_cont_r <= repeat_r == 8'h00;
    end else if (slot) begin
      case (tx_state_r)
        TX_ALIGN: begin
          if (pos == 2'd0) begin
            tx_state_r <= TX_SEND;
          end
        end
        TX_SEND: begin
          // RULE17: count whole codes, zero runs forever
          if (pos == 2'd3 && !tx_cont_r) begin
            tx_left_r <= tx_left_r - 8'h01;
            // RULE20: then all ones
            if (tx_left_r == 8'h01) begin
              tx_state_r <= TX_ONES;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // RULE2: bit for this slot, MSB at position 0
  always_comb begin
    ins_bit = 1'b1;
    if (tx_state_r == TX_SEND || (tx_state_r == TX_ALIGN && pos == 2'd0)) begin
      ins_bit = tx_word_r[2'd3 - pos];
    end
  end

  // Overhead output, updated once per frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_out <= '{sa_tx: 5'h1f, si_tx: 1'b1};
    end else if (frame_in.frame_tick) begin
      tx_out.sa_tx <= frame_in.sa_tx_in;
      tx_out.si_tx <= frame_in.si_tx_in;
      if (slot && tx_state_r != TX_PASS) begin
        // RULE4: source bit picks the carrier
        if (control_r[`CTL_SRC_BIT]) begin
          // RULE7: Si path relies on CRC multiframe being set up
          tx_out.si_tx <= ins_bit;
        end else begin
          // RULE5: override enabled national slots
          // RULE1: any of Sa4..Sa8
          tx_out.sa_tx <= (frame_in.sa_tx_in & ~slot_en_r) | (slot_en_r & {5{ins_bit}});
        end
      end
    end
  end

  // RULE6: lowest enabled national slot is the receive carrier
  always_comb begin
    rx_bit = frame_in.sa_rx[0];
    for (int i = 4; i >= 0; i--) begin
      if (slot_en_r[i]) begin
        rx_bit = frame_in.sa_rx[i];
      end
    end
    // RULE4: same source select on receive
    if (control_r[`CTL_SRC_BIT]) begin
      rx_bit = frame_in.si_rx;
    end
  end

  // Receive nibble assembly; a nibble counts only if seen from its MSB
  always_ff @(posedge aclk) begin
    if (!aresetn || code_reset) begin
      rx_shift_r <= 3'h0;
      rx_run_r <= 1'b0;
      rx_stb_r <= 1'b0;
      rx_code_r <= 4'h0;
    end else begin
      rx_stb_r <= 1'b0;
      // RULE9: only while enabled
      if (!control_r[`CTL_RXEN_BIT]) begin
        rx_run_r <= 1'b0;
      end else if (slot) begin
        rx_shift_r <= {rx_shift_r[1:0], rx_bit};
        // A run opens on the MSB slot and closes after the LSB slot
        rx_run_r <= (pos == 2'd0) || (rx_run_r && pos != 2'd3);
        if (pos == 2'd3 && rx_run_r) begin
          rx_stb_r <= 1'b1;
          rx_code_r <= {rx_shift_r, rx_bit};
        end
      end
    end
  end

  // RULE11: receive filter
  ssm_code_filter #(.CW(4), .NW(3)) u_rx_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(code_reset),
    .setting(control_r[`CTL_RF_HI:`CTL_RF_LO]),
    .code_stb(rx_stb_r),
    .code(rx_code_r),
    .pass(rx_pass),
    .pass_code(rx_pass_code)
  );

  // RULE8: shared match filter
  ssm_code_filter #(.CW(4), .NW(3)) u_match_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(code_reset),
    .setting(control_r[`CTL_MF_HI:`CTL_MF_LO]),
    .code_stb(rx_stb_r),
    .code(rx_code_r),
    .pass(match_pass),
    .pass_code(match_code)
  );

  // RULE13: code history shift
  always_ff @(posedge aclk) begin
    if (!aresetn || code_reset) begin
      history_r <= `RST_HISTORY;
    end else if (rx_pass) begin
      history_r <= {history_r[3:0], rx_pass_code};
    end
  end

  // Alarm events of this cycle
  always_comb begin
    status_set = '0;
    status_set[`ST_RX_ALARM] = rx_pass;
    // RULE16: change of status
    status_set[`ST_CHANGE] = rx_pass && rx_pass_code != history_r[3:0];
    // RULE3: codes outside the defined set are reserved
    status_set[`ST_RESERVED] = rx_pass && rx_pass_code != `QL_UNKNOWN
      && rx_pass_code != `QL_PRIMARY && rx_pass_code != `QL_SSU_A
      && rx_pass_code != `QL_SSU_B && rx_pass_code != `QL_EQUIPMENT
      && rx_pass_code != `QL_DO_NOT_USE;
    // RULE14: compare with expected codes
    // RULE15: one alarm per expected code
    for (int m = 0; m < 3; m++) begin
      status_set[`ST_MATCH1 + m] = match_pass && match_code == expect_r[m];
    end
  end

  // Sticky alarms; write one clears, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
    end else if (wr_do && w_lane_r && wr_sel == SEL_STATUS) begin
      status_r <= (status_r & ~w_data_r[`ST_WIDTH-1:0]) | status_set;
    end else begin
      status_r <= status_r | status_set;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_send_write;
    send_req;
  endsequence

  sequence s_first_bit;
    slot && (tx_state_r == TX_SEND || tx_state_r == TX_ALIGN) && pos == 2'd0
      && !control_r[`CTL_SRC_BIT];
  endsequence

  property p_send_start;
    s_send_write |=> tx_state_r == TX_ALIGN && tx_word_r == $past(tx_code_r);
  endproperty
  a_send_start: assert property (p_send_start) else $error("send not started"); // RULE12

  property p_reset_defaults;
    code_reset |=> control_r == `RST_CONTROL && repeat_r == `RST_REPEAT
      && history_r == `RST_HISTORY && tx_state_r == TX_PASS
      && status_r == ($past(status_r) | $past(status_set));
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset incomplete"); // RULE10

  property p_msb_first;
    s_first_bit ##0 slot_en_r != 5'h00 |=> (tx_out.sa_tx & slot_en_r)
      == ({5{$past(tx_word_r[3])}} & slot_en_r);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not MSB"); // RULE2

  property p_history;
    rx_pass && !code_reset |=> history_r[3:0] == $past(rx_pass_code)
      && history_r[7:4] == $past(history_r[3:0]);
  endproperty
  a_history: assert property (p_history) else $error("history not shifted"); // RULE13

  property p_match1;
    match_pass && match_code == expect_r[0] |=> status_r[`ST_MATCH1];
  endproperty
  a_match1: assert property (p_match1) else $error("match alarm missing"); // RULE14

  property p_change;
    rx_pass && rx_pass_code != history_r[3:0] |=> status_r[`ST_CHANGE];
  endproperty
  a_change: assert property (p_change) else $error("change alarm missing"); // RULE16

  property p_rx_disabled;
    !control_r[`CTL_RXEN_BIT] && !$past(control_r[`CTL_RXEN_BIT]) |-> !rx_stb_r;
  endproperty
  a_rx_disabled: assert property (p_rx_disabled) else $error("receiver ran disabled"); // RULE9

  property p_last_repeat;
    slot && tx_state_r == TX_SEND && pos == 2'd3 && !tx_cont_r && tx_left_r == 8'h01
      && !send_req && !code_reset |=> tx_state_r == TX_ONES;
  endproperty
  a_last_repeat: assert property (p_last_repeat) else $error("repeat count ignored"); // RULE17

  property p_ones_after;
    tx_state_r == TX_ONES && slot && control_r[`CTL_SRC_BIT] |=> tx_out.si_tx;
  endproperty
  a_ones_after: assert property (p_ones_after) else $error("ones not sent"); // RULE20

endmodule

// >>> common/ssm_consts.svh
// Register indices, field positions, reset values and fixed counts of the
// E1 synchronization status code unit.
// Assumes inclusion by bare name from the design files.
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

// Register indices; byte address is four times the index
`define SSM_IDX_CONTROL 10'h170
`define SSM_IDX_HISTORY 10'h171
`define SSM_IDX_EXPECT1 10'h172
`define SSM_IDX_EXPECT2 10'h173
`define SSM_IDX_EXPECT3 10'h174
`define SSM_IDX_TX_CODE 10'h175
`define SSM_IDX_REPEAT 10'h176
`define SSM_IDX_STATUS 10'h180
`define SSM_IDX_SLOT_EN 10'h181

// Control register fields
`define CTL_SRC_BIT 7
`define CTL_MF_HI 6
`define CTL_MF_LO 5
`define CTL_RXEN_BIT 4
`define CTL_RST_BIT 3
`define CTL_RF_HI 2
`define CTL_RF_LO 1
`define CTL_SEND_BIT 0
`define CTL_STORE_MASK 8'hf6

// Status register fields (sticky, write one to clear)
`define ST_RX_ALARM 0
`define ST_CHANGE 1
`define ST_MATCH1 2
`define ST_RESERVED 5
`define ST_WIDTH 6

// Reset values
`define RST_CONTROL 8'h00
`define RST_EXPECT 4'h0
`define RST_TX_CODE 4'h0
`define RST_REPEAT 8'h01
`define RST_SLOT_EN 5'h01
`define RST_HISTORY 8'h00

// Quality codes
`define QL_UNKNOWN 4'h0
`define QL_PRIMARY 4'h2
`define QL_SSU_A 4'h4
`define QL_SSU_B 4'h8
`define QL_EQUIPMENT 4'hb
`define QL_DO_NOT_USE 4'hf

// Consecutive pattern counts for filter settings 00, 01, 10, 11
`define FILT_COUNT0 3'h1
`define FILT_COUNT1 3'h3
`define FILT_COUNT2 3'h5
`define FILT_COUNT3 3'h7

// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> common/ssm_pkg.sv
// Types shared by the status code unit and its surroundings.
// Assumes the framer supplies one frame strobe per E1 frame on aclk.
package ssm_pkg;

  // Per-frame overhead from the framer; frame_num 0..15 within the CRC multiframe
  typedef struct packed {
    logic frame_tick;
    logic [3:0] frame_num;
    logic [4:0] sa_rx;
    logic si_rx;
    logic [4:0] sa_tx_in;
    logic si_tx_in;
  } frame_side_t;

  // Overhead bits handed back to the transmit framer
  typedef struct packed {
    logic [4:0] sa_tx;
    logic si_tx;
  } tx_side_t;

  typedef enum logic [1:0] {TX_PASS, TX_ALIGN, TX_SEND, TX_ONES} tx_state_t;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_CONTROL, SEL_HISTORY, SEL_EXPECT1, SEL_EXPECT2, SEL_EXPECT3,
    SEL_TX_CODE, SEL_REPEAT, SEL_STATUS, SEL_SLOT_EN
  } reg_sel_t;

endpackage

// >>> hw/ssm_code_filter.sv
// Consecutive pattern qualifier for received 4-bit status codes.
// Assumes code strobes and the clear pulse come from logic on aclk.
`timescale 1ns/100ps
`include "ssm_consts.svh"

module ssm_code_filter #(
  parameter int CW = 4,
  parameter int NW = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic clear,
  input wire logic [1:0] setting,
  // Incoming codes
  input wire logic code_stb,
  input wire logic [CW-1:0] code,
  // Qualified code
  output logic pass,
  output logic [CW-1:0] pass_code
);
  import ssm_pkg::*;

  logic [NW-1:0] cnt_r;
  logic [NW-1:0] cnt_nxt;
  logic [CW-1:0] cand_r;
  logic [NW-1:0] need;

  // Count of identical patterns required by a filter setting
  function automatic logic [NW-1:0] need_count(input logic [1:0] s);
    case (s)
      2'b00: need_count = NW'(`FILT_COUNT0);
      2'b01: need_count = NW'(`FILT_COUNT1);
      2'b10: need_count = NW'(`FILT_COUNT2);
      default: need_count = NW'(`FILT_COUNT3);
    endcase
  endfunction

  assign need = need_count(setting);

  // A different code restarts the run at one
  always_comb begin
    cnt_nxt = cnt_r;
    if (code_stb) begin
      if (code != cand_r || cnt_r == '0) begin
        cnt_nxt = NW'(1);
      end else if (cnt_r < need) begin
        cnt_nxt = cnt_r + NW'(1);
      end
    end
  end

  // Run counter and candidate code
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_r <= '0;
      cand_r <= '0;
    end else if (code_stb) begin
      cnt_r <= cnt_nxt;
      cand_r <= code;
    end
  end

  // Pass fires once, when the run first reaches the required length
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      pass <= 1'b0;
      pass_code <= '0;
    end else begin
      pass <= code_stb && cnt_nxt == need && (cnt_r != need || code != cand_r);
      if (code_stb) begin
        pass_code <= code;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_restart;
    code_stb && !clear && code != cand_r |=> cnt_r == NW'(1);
  endproperty
  a_restart: assert property (p_restart) else $error("run did not restart"); // RULE19

  property p_pass_len;
    pass |-> $past(cnt_nxt) == $past(need) && cnt_r == $past(need);
  endproperty
  a_pass_len: assert property (p_pass_len) else $error("pass before run length"); // RULE11

endmodule

// >>> test/ssm_framer_model.sv
// Far-end framer model: frame strobes, received overhead bits and capture
// of the transmitted code bit. Assumes the unit samples frame_in at ticks.
`timescale 1ns/100ps

module ssm_framer_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Code sent by the far end and the bit that carries it
  input wire logic [3:0] rx_code,
  input wire logic use_si,
  // Overhead exchanged with the unit
  input wire ssm_pkg::tx_side_t tx_out,
  output ssm_pkg::frame_side_t frame_in,
  // Last whole nibble seen on the transmit bit
  output logic [3:0] nib,
  output logic nib_stb
);
  import ssm_pkg::*;
  logic [2:0] cyc_r;
  logic [3:0] fnum_r, seen_fnum_r, shift_r;
  logic tick, slot_bit, seen_r, tx_bit;
  assign tick = (cyc_r == 3'h7);
  assign slot_bit = fnum_r[0] ? rx_code[~fnum_r[2:1]] : 1'b1;
  assign tx_bit = use_si ? tx_out.si_tx : tx_out.sa_tx[0];
  // Fields hold only at the tick; inverted between ticks
  always_comb begin
    frame_in.frame_tick = tick;
    frame_in.frame_num = tick ? fnum_r : ~fnum_r;
    frame_in.sa_rx = {5{(use_si | slot_bit) ^ ~tick}};
    frame_in.si_rx = (~use_si | slot_bit) ^ ~tick;
    frame_in.sa_tx_in = {5{~tick}};
    frame_in.si_tx_in = ~tick;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_r <= 3'h0;
      fnum_r <= 4'h0;
    end else begin
      cyc_r <= cyc_r + 3'h1;
      if (tick) fnum_r <= fnum_r + 4'h1;
    end
  end
  // Collect slot-frame bits one cycle after each tick
  always_ff @(posedge aclk) begin
    seen_r <= tick;
    seen_fnum_r <= fnum_r;
    nib_stb <= 1'b0;
    if (seen_r && seen_fnum_r[0]) begin
      shift_r <= {shift_r[2:0], tx_bit};
      if (seen_fnum_r[2:1] == 2'h3) begin
        nib <= {shift_r[2:0], tx_bit};
        nib_stb <= 1'b1;
      end
    end
  end
endmodule

// >>> test/e1_ssm_code_transceiver_tb.sv
// Bench for the status code unit: AXI4-Lite register access and code
// traffic through the framer model. Assumes one 10 MHz clock.
`timescale 1ns/100ps
`include "ssm_consts.svh"

module e1_ssm_code_transceiver_tb;
  import ssm_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, use_si, nib_stb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, rx_code, nib, v;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] got;
  frame_side_t frame_in;
  tx_side_t tx_out;
  int err_total, comparisons;

  e1_ssm_code_transceiver #(.AW(12)) uut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .frame_in, .tx_out);
  ssm_framer_model far (.aclk, .aresetn, .rx_code, .use_si, .tx_out, .frame_in, .nib,
    .nib_stb);

  // Clock at 100 ns
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [9:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    got = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
    rd(idx);
    chk(got, e);
  endtask

  // Wait for the next nibble captured on the transmit bit
  task automatic next_nib();
    do @(posedge aclk); while (!nib_stb);
    v = nib;
    repeat (2) @(posedge aclk);
  endtask

  task automatic seek(input logic [3:0] c);
    v = ~c;
    for (int i = 0; i < 8 && v !== c; i++) next_nib();
    chk({4'h0, v}, {4'h0, c});
  endtask

  task automatic chk_defaults();
    rdc(`SSM_IDX_CONTROL, `RST_CONTROL);
    rdc(`SSM_IDX_HISTORY, `RST_HISTORY);
    rdc(`SSM_IDX_EXPECT1, {4'h0, `RST_EXPECT});
    rdc(`SSM_IDX_TX_CODE, {4'h0, `RST_TX_CODE});
    rdc(`SSM_IDX_REPEAT, `RST_REPEAT);
    rdc(`SSM_IDX_SLOT_EN, {3'h0, `RST_SLOT_EN});
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, use_si} = 7'h0;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'h1;
    rx_code = `QL_SSU_A;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_defaults();
    rd(10'h100);
    chk({6'h0, resp}, {6'h0, `RESP_SLVERR});
    next_nib();
    chk({4'h0, v}, 8'h00);
    wr(`SSM_IDX_TX_CODE, {4'h0, `QL_EQUIPMENT});
    wr(`SSM_IDX_CONTROL, 8'h01);
    rdc(`SSM_IDX_CONTROL, 8'h00);
    seek(`QL_EQUIPMENT);
    next_nib();
    chk({4'h0, v}, 8'h0f);
    wr(`SSM_IDX_REPEAT, 8'h00);
    use_si <= 1'b1;
    wr(`SSM_IDX_TX_CODE, {4'h0, `QL_PRIMARY});
    wr(`SSM_IDX_CONTROL, 8'h81);
    seek(`QL_PRIMARY);
    repeat (3) begin
      next_nib();
      chk({4'h0, v}, {4'h0, `QL_PRIMARY});
    end
    use_si <= 1'b0;
    rdc(`SSM_IDX_HISTORY, 8'h00);
    wr(`SSM_IDX_EXPECT1, {4'h0, `QL_SSU_B});
    wr(`SSM_IDX_EXPECT2, {4'h0, `QL_SSU_B});
    wr(`SSM_IDX_CONTROL, 8'h32);
    repeat (5) next_nib();
    rdc(`SSM_IDX_HISTORY, 8'h04);
    rdc(`SSM_IDX_STATUS, 8'h03);
    wr(`SSM_IDX_STATUS, 8'h3f);
    next_nib();
    rx_code <= `QL_SSU_B;
    repeat (2) next_nib();
    rdc(`SSM_IDX_HISTORY, 8'h04);
    rdc(`SSM_IDX_STATUS, 8'h00);
    next_nib();
    rdc(`SSM_IDX_HISTORY, 8'h48);
    rdc(`SSM_IDX_STATUS, 8'h0f);
    wr(`SSM_IDX_CONTROL, 8'h08);
    chk_defaults();
    rdc(`SSM_IDX_STATUS, 8'h0f);
    // Reserved code with both filters at one pattern
    rx_code <= 4'h1;
    wr(`SSM_IDX_CONTROL, 8'h10);
    repeat (3) next_nib();
    rdc(`SSM_IDX_HISTORY, 8'h01);
    rdc(`SSM_IDX_STATUS, 8'h2f);
    tally_and_finish();
  end
endmodule
